//--- swc_pkg.sv
// Constants for the switch-input command decoder and configuration set.
// Assumes one 50 MHz system clock; serial pins arrive asynchronously.
// Contract
// [RULE1] Battery supply application performs power-on reset, then Normal mode.
// [RULE2] Reset defaults: battery polarity, all wake, high current, timers on.
// [RULE3] Reset sets output bit 22; next chip-select rise clears it.
// [RULE4] Normal mode entered on supply, switch change, wake, interrupt, select, timer.
// [RULE5] Configuration writes accepted only in Normal mode with logic supply.
// [RULE6] Switch states captured into output register at chip-select fall.
// [RULE7] Interrupt released at chip-select rise unless a switch closed meanwhile.
// [RULE8] Command 01 loads programmable-input polarity from bits 7..0.
// [RULE9] Closed input reads one, open reads zero, whatever polarity.
// [RULE10] Commands 02/03 set wake enables for programmable/ground inputs.
// [RULE11] Enabled input change asserts interrupt and wakes from Sleep.
// [RULE12] Commands 04/05 set wetting level; one is high current.
// [RULE13] Each input has 20 ms timer from threshold crossing; expiry lowers current.
// [RULE14] Timer disabled keeps selected wetting current without reduction.
// [RULE15] Commands 07/08 load wetting timer enables.
// [RULE16] Frames are 24 bits MSB first; sample on fall, shift on rise.
// [RULE17] Received word committed only at chip-select rise ending frame.
// [RULE18] Undefined command bytes leave configuration unchanged.
package swc_pkg;
  localparam int NUM_PROG = 8;
  localparam int NUM_GND = 14;
  localparam int NUM_IN = 22;
  localparam int FRAME_BITS = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 16;
  localparam int RESET_FLAG_BIT = 22;
  localparam logic [7:0] CMD_POLARITY = 8'h01;
  localparam logic [7:0] CMD_WAKE_PROG = 8'h02;
  localparam logic [7:0] CMD_WAKE_GND = 8'h03;
  localparam logic [7:0] CMD_LEVEL_PROG = 8'h04;
  localparam logic [7:0] CMD_LEVEL_GND = 8'h05;
  localparam logic [7:0] CMD_TIMER_PROG = 8'h07;
  localparam logic [7:0] CMD_TIMER_GND = 8'h08;
  localparam logic [7:0] CMD_RESET = 8'h7F;
  localparam logic [7:0] POLARITY_RESET = 8'hFF;
  localparam logic [21:0] WAKE_RESET = 22'h3FFFFF;
  localparam logic [21:0] LEVEL_RESET = 22'h3FFFFF;
  localparam logic [21:0] TIMER_RESET = 22'h3FFFFF;
  localparam int CLK_HZ = 50_000_000;
  localparam int WET_MS = 20;
  localparam int WET_CYCLES = (CLK_HZ / 1000) * WET_MS;
  localparam int WET_W = 20;
endpackage

//--- swc_sync.sv
// Three-flop synchroniser with agreement filter for one asynchronous pin.
// Assumes sys_clk domain; output changes when stages two and three agree.
`timescale 1ns/1ns
module swc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lv_q;
  logic       lv_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin_in};
    lv_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lv_q;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_q <= {3{RST_VAL}};
      lv_q <= RST_VAL;
    end else begin
      sh_q <= sh_d;
      lv_q <= lv_d;
    end
  end

  assign level_out = lv_q;
endmodule // swc_sync

//--- swc_wet_timer.sv
// One wetting current timer: counts from a comparator crossing to expiry.
// Assumes the closed level is already synchronised to sys_clk.
`timescale 1ns/1ns
module swc_wet_timer (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic closed,
  input  wire logic timer_en,
  input  wire logic level_high,
  output logic      high_current
);
  logic [swc_pkg::WET_W-1:0] cnt_q;
  logic [swc_pkg::WET_W-1:0] cnt_d;
  logic                      prev_q;
  logic                      prev_d;
  logic                      hi_q;
  logic                      hi_d;
  logic                      expired;

  assign expired = (cnt_q == swc_pkg::WET_W'(swc_pkg::WET_CYCLES - 1));

  always_comb begin
    prev_d = closed;
    cnt_d  = cnt_q;
    if (closed != prev_q) begin
      cnt_d = '0; // RULE13
    end else if (!expired) begin
      cnt_d = cnt_q + 1'b1;
    end
    // Disabled timer never reduces current
    hi_d = level_high && (!timer_en || !expired); // RULE14
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q  <= '0;
      prev_q <= 1'b0;
      hi_q   <= 1'b1;
    end else begin
      cnt_q  <= cnt_d;
      prev_q <= prev_d;
      hi_q   <= hi_d;
    end
  end

  assign high_current = hi_q;
endmodule // swc_wet_timer

//--- swc_top.sv
// Command decoder, configuration set and serial port of the switch monitor.
// Assumes serial pins and wake/interrupt-in are asynchronous to sys_clk.
`timescale 1ns/1ns
module swc_top (
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  input  wire logic                         logic_supply_ok,
  input  wire logic                         sclk,
  input  wire logic                         cs_n,
  input  wire logic                         si,
  input  wire logic                         wake_n_in,
  input  wire logic                         int_n_in,
  input  wire logic                         timer_expired,
  input  wire logic [swc_pkg::NUM_PROG-1:0] programmable_input,
  input  wire logic [swc_pkg::NUM_GND-1:0]  ground_only_input,
  output logic                              so_o,
  output logic                              so_oe_n,
  output logic                              int_n_oe_n,
  output logic                              normal_mode,
  output logic [swc_pkg::NUM_PROG-1:0]      input_polarity_select,
  output logic [swc_pkg::NUM_IN-1:0]        wake_interrupt_enable,
  output logic [swc_pkg::NUM_IN-1:0]        wetting_level_select,
  output logic [swc_pkg::NUM_IN-1:0]        wetting_timer_enable,
  output logic [swc_pkg::NUM_IN-1:0]        high_current_on
);
  // Synchronised pins
  logic                           sclk_s;
  logic                           cs_n_s;
  logic                           si_s;
  logic                           wake_s;
  logic                           intin_s;
  logic                           tmr_s;
  logic [swc_pkg::NUM_IN-1:0]     raw_s;
  logic [swc_pkg::NUM_IN-1:0]     closed;
  logic [swc_pkg::NUM_IN-1:0]     hi_cur;

  // State
  logic [swc_pkg::NUM_PROG-1:0]   pol_q;
  logic [swc_pkg::NUM_PROG-1:0]   pol_d;
  logic [swc_pkg::NUM_IN-1:0]     wake_q;
  logic [swc_pkg::NUM_IN-1:0]     wake_d;
  logic [swc_pkg::NUM_IN-1:0]     lvl_q;
  logic [swc_pkg::NUM_IN-1:0]     lvl_d;
  logic [swc_pkg::NUM_IN-1:0]     tmr_en_q;
  logic [swc_pkg::NUM_IN-1:0]     tmr_en_d;
  logic [swc_pkg::NUM_IN-1:0]     last_q;
  logic [swc_pkg::NUM_IN-1:0]     last_d;
  logic [swc_pkg::FRAME_BITS-1:0] rx_q;
  logic [swc_pkg::FRAME_BITS-1:0] rx_d;
  logic [swc_pkg::FRAME_BITS-1:0] tx_q;
  logic [swc_pkg::FRAME_BITS-1:0] tx_d;
  logic [4:0]                     cnt_q;
  logic [4:0]                     cnt_d;
  logic                           sclk_p_q;
  logic                           cs_p_q;
  logic                           wake_p_q;
  logic                           intin_p_q;
  logic                           tmr_p_q;
  logic                           rst_flag_q;
  logic                           rst_flag_d;
  logic                           int_q;
  logic                           int_d;
  logic                           closed_in_frame_q;
  logic                           closed_in_frame_d;
  logic                           normal_q;
  logic                           normal_d;
  logic                           so_q;
  logic                           so_d;
  logic                           so_oe_n_q;
  logic                           so_oe_n_d;
  logic                           int_oe_n_q;
  logic                           int_oe_n_d;
  logic [swc_pkg::NUM_IN-1:0]     hi_q;
  logic [swc_pkg::NUM_IN-1:0]     hi_d;

  logic                           cs_fall;
  logic                           cs_rise;
  logic                           sclk_fall;
  logic                           sclk_rise;
  logic                           cfg_ok;
  logic                           enabled_chg;
  logic                           closing;
  logic [7:0]                     cmd;

  // Each pin lags about four cycles; link phases must be longer than that
  swc_sync #(.RST_VAL(1'b0)) u_sclk (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (sclk),
    .level_out (sclk_s)
  );
  swc_sync #(.RST_VAL(1'b1)) u_cs (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (cs_n),
    .level_out (cs_n_s)
  );
  swc_sync #(.RST_VAL(1'b0)) u_si (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (si),
    .level_out (si_s)
  );
  swc_sync #(.RST_VAL(1'b1)) u_wk (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (wake_n_in),
    .level_out (wake_s)
  );
  swc_sync #(.RST_VAL(1'b1)) u_in (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (int_n_in),
    .level_out (intin_s)
  );
  swc_sync #(.RST_VAL(1'b0)) u_tm (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .pin_in    (timer_expired),
    .level_out (tmr_s)
  );

  genvar g;
  generate
    for (g = 0; g < swc_pkg::NUM_IN; g++) begin : g_in
      logic pin;
      if (g < swc_pkg::NUM_GND) begin : g_gnd
        assign pin = ground_only_input[g];
      end else begin : g_prg
        assign pin = programmable_input[g - swc_pkg::NUM_GND];
      end
      // Resets to the idle high level so release shows no false change
      swc_sync #(.RST_VAL(1'b1)) u_sw (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pin_in    (pin),
        .level_out (raw_s[g])
      );
      swc_wet_timer u_wt (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .closed       (closed[g]),
        .timer_en     (tmr_en_q[g]),
        .level_high   (lvl_q[g]),
        .high_current (hi_cur[g])
      );
    end
  endgenerate

  // Inputs arrive as comparator "above threshold": ground inputs close low,
  // programmable inputs close high when set to battery polarity
  always_comb begin
    for (int i = 0; i < swc_pkg::NUM_GND; i++) begin
      closed[i] = !raw_s[i]; // RULE9
    end
    for (int j = 0; j < swc_pkg::NUM_PROG; j++) begin
      closed[swc_pkg::NUM_GND + j] = raw_s[swc_pkg::NUM_GND + j] ~^ pol_q[j]; // RULE9
    end
  end

  assign cs_fall   = cs_p_q && !cs_n_s;
  assign cs_rise   = !cs_p_q && cs_n_s;
  assign sclk_fall = sclk_p_q && !sclk_s && !cs_n_s;
  assign sclk_rise = !sclk_p_q && sclk_s && !cs_n_s;
  assign cfg_ok    = normal_q && logic_supply_ok; // RULE5
  assign cmd       = rx_q[swc_pkg::CMD_MSB:swc_pkg::CMD_LSB];
  assign enabled_chg = |((closed ^ last_q) & wake_q); // RULE11
  assign closing   = |(closed & ~last_q & wake_q);

  always_comb begin
    pol_d = pol_q;
    wake_d = wake_q;
    lvl_d = lvl_q;
    tmr_en_d = tmr_en_q;
    rx_d = rx_q;
    tx_d = tx_q;
    cnt_d = cnt_q;
    rst_flag_d = rst_flag_q;
    int_d = int_q || enabled_chg; // RULE11
    closed_in_frame_d = closed_in_frame_q;
    normal_d = normal_q;
    so_d = so_q;
    so_oe_n_d = so_oe_n_q;
    last_d = closed;
    hi_d = hi_cur & closed; // RULE13

    // Normal mode entry events; Sleep belongs to the excluded logic
    if (enabled_chg || (wake_p_q && !wake_s) || (tmr_s && !tmr_p_q) ||
        (intin_p_q && !intin_s && logic_supply_ok && wake_s) ||
        (cs_fall && logic_supply_ok)) begin
      normal_d = 1'b1; // RULE4
    end

    if (cs_fall) begin
      tx_d = '0;
      tx_d[swc_pkg::RESET_FLAG_BIT] = rst_flag_q; // RULE3
      tx_d[swc_pkg::NUM_IN-1:0] = closed; // RULE6
      cnt_d = '0;
      so_oe_n_d = 1'b0;
      closed_in_frame_d = 1'b0;
    end
    if (!cs_n_s && closing) begin
      closed_in_frame_d = 1'b1;
    end
    if (sclk_fall) begin
      rx_d = {rx_q[swc_pkg::FRAME_BITS-2:0], si_s}; // RULE16
      if (cnt_q != 5'(swc_pkg::FRAME_BITS)) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (sclk_rise) begin
      so_d = tx_q[swc_pkg::FRAME_BITS-1]; // RULE16
      tx_d = {tx_q[swc_pkg::FRAME_BITS-2:0], 1'b0};
    end

    if (cs_rise) begin
      so_oe_n_d = 1'b1;
      rst_flag_d = 1'b0; // RULE3
      // Set wins: an enabled change in this very cycle keeps the interrupt
      if (!closed_in_frame_q && !enabled_chg) begin
        int_d = 1'b0; // RULE7
      end
      if (cfg_ok && cnt_q == 5'(swc_pkg::FRAME_BITS)) begin // RULE17
        unique case (cmd)
          swc_pkg::CMD_POLARITY:   pol_d = rx_q[7:0]; // RULE8
          swc_pkg::CMD_WAKE_PROG:  wake_d[21:14] = rx_q[7:0]; // RULE10
          swc_pkg::CMD_WAKE_GND:   wake_d[13:0] = rx_q[13:0]; // RULE10
          swc_pkg::CMD_LEVEL_PROG: lvl_d[21:14] = rx_q[7:0]; // RULE12
          swc_pkg::CMD_LEVEL_GND:  lvl_d[13:0] = rx_q[13:0]; // RULE12
          swc_pkg::CMD_TIMER_PROG: tmr_en_d[21:14] = rx_q[7:0]; // RULE15
          swc_pkg::CMD_TIMER_GND:  tmr_en_d[13:0] = rx_q[13:0]; // RULE15
          swc_pkg::CMD_RESET: begin
            pol_d = swc_pkg::POLARITY_RESET; // RULE2
            wake_d = swc_pkg::WAKE_RESET;
            lvl_d = swc_pkg::LEVEL_RESET;
            tmr_en_d = swc_pkg::TIMER_RESET;
            rst_flag_d = 1'b1; // RULE3
          end
          default: ; // RULE18
        endcase
      end
    end
    int_oe_n_d = !int_d;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin // RULE1
      pol_q <= swc_pkg::POLARITY_RESET; // RULE2
      wake_q <= swc_pkg::WAKE_RESET;
      lvl_q <= swc_pkg::LEVEL_RESET;
      tmr_en_q <= swc_pkg::TIMER_RESET;
      last_q <= {{swc_pkg::NUM_PROG{1'b1}}, {swc_pkg::NUM_GND{1'b0}}};
      rx_q <= '0;
      tx_q <= '0;
      cnt_q <= '0;
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      wake_p_q <= 1'b1;
      intin_p_q <= 1'b1;
      tmr_p_q <= 1'b0;
      rst_flag_q <= 1'b1; // RULE3
      int_q <= 1'b0;
      closed_in_frame_q <= 1'b0;
      normal_q <= 1'b1; // RULE1
      so_q <= 1'b0;
      so_oe_n_q <= 1'b1;
      int_oe_n_q <= 1'b1;
      hi_q <= '0;
    end else begin
      pol_q <= pol_d;
      wake_q <= wake_d;
      lvl_q <= lvl_d;
      tmr_en_q <= tmr_en_d;
      last_q <= last_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cnt_q <= cnt_d;
      sclk_p_q <= sclk_s;
      cs_p_q <= cs_n_s;
      wake_p_q <= wake_s;
      intin_p_q <= intin_s;
      tmr_p_q <= tmr_s;
      rst_flag_q <= rst_flag_d;
      int_q <= int_d;
      closed_in_frame_q <= closed_in_frame_d;
      normal_q <= normal_d;
      so_q <= so_d;
      so_oe_n_q <= so_oe_n_d;
      int_oe_n_q <= int_oe_n_d;
      hi_q <= hi_d;
    end
  end

  assign so_o = so_q;
  assign so_oe_n = so_oe_n_q;
  assign int_n_oe_n = int_oe_n_q;
  assign normal_mode = normal_q;
  assign input_polarity_select = pol_q;
  assign wake_interrupt_enable = wake_q;
  assign wetting_level_select = lvl_q;
  assign wetting_timer_enable = tmr_en_q;
  assign high_current_on = hi_q;
endmodule // swc_top

//--- swc_props.sv
// Checker for the switch decoder: serial enable, commit and interrupt timing.
// Assumes it is bound to swc_top and sees only its ports.
`timescale 1ns/1ns
module swc_props (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        cs_n,
  input wire logic        logic_supply_ok,
  input wire logic        so_oe_n,
  input wire logic        int_n_oe_n,
  input wire logic        normal_mode,
  input wire logic [7:0]  input_polarity_select,
  input wire logic [21:0] wake_interrupt_enable,
  input wire logic [21:0] wetting_level_select,
  input wire logic [21:0] wetting_timer_enable,
  input wire logic [21:0] high_current_on
);
  logic [3:0]  hi_q;
  logic [3:0]  hi_d;
  logic [73:0] cfg;
  assign cfg = {input_polarity_select, wake_interrupt_enable,
                wetting_level_select, wetting_timer_enable};
  // Cycles since cs_n rose; saturates so idle time never aliases a commit
  always_comb begin
    hi_d = (hi_q == 4'hF) ? hi_q : hi_q + 4'h1;
    if (!cs_n)
      hi_d = 4'h0;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      hi_q <= 4'hF;
    else
      hi_q <= hi_d;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  so_release_a: assert property (
    cs_n [*8] |-> so_oe_n) else $error("serial out driven while idle");
  so_drive_a: assert property (
    (!cs_n) [*8] |-> !so_oe_n) else $error("serial out idle in frame");
  cfg_commit_a: assert property (
    $changed(cfg) |-> cs_n && hi_q inside {[1:12]}) else $error("config changed off commit");
  cfg_supply_a: assert property (
    $changed(cfg) |-> logic_supply_ok || $past(logic_supply_ok))
    else $error("config changed without supply");
  rst_dflt_a: assert property (
    disable iff (1'b0) sys_rst |-> cfg == {74{1'b1}}) else $error("bad reset defaults");
  mode_on_a: assert property (
    normal_mode) else $error("left normal mode");
  int_rel_a: assert property (
    $rose(int_n_oe_n) |-> cs_n && hi_q inside {[1:12]}) else $error("interrupt freed off commit");
  int_set_a: assert property (
    $fell(int_n_oe_n) |-> $past(wake_interrupt_enable) != 22'h000000)
    else $error("interrupt with all inputs disabled");
  lvl_high_a: assert property (
    (high_current_on & ~wetting_level_select & ~$past(wetting_level_select)
     & ~$past(wetting_level_select, 2)) == 22'h000000) else $error("high current not selected");
endmodule // swc_props
bind swc_top swc_props swc_props_inst (.sys_clk, .sys_rst, .cs_n, .logic_supply_ok, .so_oe_n,
  .int_n_oe_n, .normal_mode, .input_polarity_select, .wake_interrupt_enable,
  .wetting_level_select, .wetting_timer_enable, .high_current_on);

//--- swc_host.sv
// Host model: serial master sending frames and reading the response.
// Assumes the device samples on sclk falls; sclk stands low between frames.
`timescale 1ns/1ns
module swc_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_o,
  input  wire logic so_oe_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // Sends the low n bits of w, MSB first; only n of 24 is a real frame
  task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
    r = 24'h000000;
    cs_n = 1'b0;
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      si = w[i];
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
      #80;
      r = {r[22:0], (so_oe_n === 1'b0) ? so_o : 1'bx};
    end
    cs_n = 1'b1;
    si = ~si; // Released line must not keep the last bit
    #400;
  endtask
endmodule // swc_host

//--- testbench.sv
// Bench: host frames against the switch command decoder and config set.
// Assumes swc_host drives the serial pins with a 160 ns link clock.
`timescale 1ns/1ns
module testbench;
  logic        sys_clk, sys_rst, logic_supply_ok, wake_n_in, int_n_in, timer_expired;
  logic        sclk, cs_n, si, so_o, so_oe_n, int_n_oe_n, normal_mode;
  logic [7:0]  programmable_input, input_polarity_select;
  logic [13:0] ground_only_input;
  logic [21:0] wake_interrupt_enable, wetting_level_select, wetting_timer_enable;
  logic [21:0] high_current_on;
  logic [23:0] rsp;
  int          err_total = 0;
  int          n_compared = 0;
  swc_top swc_top_inst (.sys_clk, .sys_rst, .logic_supply_ok, .sclk, .cs_n, .si, .wake_n_in,
    .int_n_in, .timer_expired, .programmable_input, .ground_only_input, .so_o, .so_oe_n,
    .int_n_oe_n, .normal_mode, .input_polarity_select, .wake_interrupt_enable,
    .wetting_level_select, .wetting_timer_enable, .high_current_on);
  swc_host swc_host_inst (.sclk, .cs_n, .si, .so_o, .so_oe_n);
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic frm(input logic [23:0] w);
    swc_host_inst.xfer(w, 24, rsp);
  endtask
  function automatic logic [79:0] cfg();
    return {input_polarity_select, wake_interrupt_enable, wetting_level_select,
            wetting_timer_enable};
  endfunction
  task automatic t_reset();
    chk(cfg(), {6'h00, {74{1'b1}}});
    frm(24'h000000);
    chk(rsp[22], 1'b1);
    frm(24'h000000);
    chk(rsp[22], 1'b0);
  endtask
  task automatic t_write();
    logic [79:0] keep;
    frm(24'h01FF3C);
    chk(input_polarity_select, 8'h3C);
    // Commands 02..05, 07, 08: even index loads programmable bits
    for (int i = 0; i < 6; i++) begin
      frm({8'h02 + 8'(i) + 8'(i / 4), i[0] ? 16'hC2C3 : 16'hFF5A});
      keep = cfg() >> (22 * (2 - i / 2));
      chk(keep[21:0], i[0] ? 22'h1682C3 : 22'h16BFFF);
    end
    keep = cfg();
    frm(24'h3CFFFF);
    chk(cfg(), keep);
    swc_host_inst.xfer(24'h010000, 23, rsp);
    chk(cfg(), keep);
    tick(1);
    logic_supply_ok = 1'b0;
    frm(24'h010000);
    tick(1);
    logic_supply_ok = 1'b1;
    chk(cfg(), keep);
  endtask
  task automatic t_capture();
    tick(1);
    programmable_input = 8'h0F;
    ground_only_input = 14'h0F0F;
    tick(20);
    frm(24'h000000);
    chk(rsp[21:0], {8'hCC, 14'h30F0});
  endtask
  task automatic t_rst_cmd();
    frm(24'h7F0000);
    chk(cfg(), {6'h00, {74{1'b1}}});
    frm(24'h000000);
    chk(rsp[22], 1'b1);
  endtask
  task automatic t_int();
    chk(int_n_oe_n, 1'b1);
    tick(1);
    ground_only_input[0] = 1'b0;
    tick(10);
    chk(int_n_oe_n, 1'b0);
    chk(high_current_on[1:0], 2'b01);
    fork
      frm(24'h000000);
      begin
        tick(100);
        ground_only_input[1] = 1'b0;
      end
    join
    chk(rsp[1:0], 2'b01);
    chk(int_n_oe_n, 1'b0);
    frm(24'h000000);
    chk(int_n_oe_n, 1'b1);
  endtask
  task automatic t_wake();
    tick(1);
    {wake_n_in, int_n_in, timer_expired} = 3'b001;
    tick(10);
    {wake_n_in, int_n_in, timer_expired} = 3'b110;
    tick(10);
    chk(normal_mode, 1'b1);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // About 17 frames of 4.4 us each; generous margin
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  initial begin
    sys_rst = 1'b1;
    {logic_supply_ok, wake_n_in, int_n_in, timer_expired} = 4'b1110;
    programmable_input = 8'hFF;
    ground_only_input = 14'h3FFF;
    tick(5);
    sys_rst = 1'b0;
    tick(5);
    t_reset();
    t_write();
    t_capture();
    t_rst_cmd();
    t_int();
    t_wake();
    end_of_test();
  end
endmodule // testbench
